/* logic/srctl_map.svh */
// Timing counts and field layout for the static RAM controller
`ifndef SRCTL_MAP_SVH
`define SRCTL_MAP_SVH
`define SRCTL_CLK_PERIOD_NS 20
`define SRCTL_ADDR_W 10
`define SRCTL_WORDS 1024
`define SRCTL_BANKS 2
// Least times in ns as printed
`define SRCTL_T_WSA_NS 1
`define SRCTL_T_WSD_NS 1
`define SRCTL_T_W_NS 7
`define SRCTL_T_WHD_NS 2
`define SRCTL_T_AA_NS 10
`define SRCTL_T_WR_NS 10
// Cycle counts, least times rounded up, never below one; access count adds two more cycles
`define SRCTL_CYC(ns) (((ns) + `SRCTL_CLK_PERIOD_NS - 1) / `SRCTL_CLK_PERIOD_NS)
`define SRCTL_SETUP_CYC `SRCTL_CYC(`SRCTL_T_WSD_NS)
`define SRCTL_PULSE_CYC `SRCTL_CYC(`SRCTL_T_W_NS)
`define SRCTL_HOLD_CYC `SRCTL_CYC(`SRCTL_T_WHD_NS)
`define SRCTL_ACCESS_CYC (`SRCTL_CYC(`SRCTL_T_AA_NS) + 2)
`define SRCTL_RECOV_CYC `SRCTL_CYC(`SRCTL_T_WR_NS)
`endif

/* logic/srctl_pkg.sv */
// Types for the static RAM controller
package srctl_pkg;
    typedef enum logic [2:0] {
        SRCTL_IDLE = 3'b000,
        SRCTL_WSETUP = 3'b001,
        SRCTL_WPULSE = 3'b010,
        SRCTL_WHOLD = 3'b011,
        SRCTL_RWAIT = 3'b100,
        SRCTL_RECOV = 3'b101
    } srctl_state_t;
endpackage

/* logic/srctl_sync.sv */
// Two-flop synchroniser for the device read bit
`timescale 1ns/100ps
`default_nettype none
module srctl_sync (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* logic/srctl_top.sv */
// Controller driving two 1Kx1 static RAMs as one 2K-word memory
`timescale 1ns/100ps
`default_nettype none
`include "srctl_map.svh"
// Function
// [R1] Each device holds 1024 one-bit locations, read and written singly.
// [R2] A 10-bit word address picks one bit; no outside decoding per device.
// [R3] Select is active low; device acts only while its select is low.
// [R4] Deselected device neither reads nor writes and drives output low.
// [R5] Selected with strobe low, device stores the input bit at the address.
// [R6] Controller holds input bit stable over setup, strobe pulse and hold.
// [R7] Selected with strobe high, device shows the addressed bit.
// [R8] Read bit equals the bit written, never inverted.
// [R9] Top address bit drives one select, its complement the other.
// [R10] Larger memories decode selects from upper address bits.
// [R11] Output is low while a write is under way.
// [R12] Stored bits change only when that location is written again.
module srctl_top
    import srctl_pkg::*;
#(
    parameter int ADDR_W = `SRCTL_ADDR_W
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_W:0] req_addr,
    input wire logic req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic rsp_rdata,
    output logic [ADDR_W-1:0] word_address,
    output logic [`SRCTL_BANKS-1:0] sel_n,
    output logic write_n,
    output logic data_in,
    input wire logic data_out
);
    localparam logic [3:0] SETUP_C = 4'(`SRCTL_SETUP_CYC);
    localparam logic [3:0] PULSE_C = 4'(`SRCTL_PULSE_CYC);
    localparam logic [3:0] HOLD_C = 4'(`SRCTL_HOLD_CYC);
    localparam logic [3:0] ACCESS_C = 4'(`SRCTL_ACCESS_CYC);
    localparam logic [3:0] RECOV_C = 4'(`SRCTL_RECOV_CYC);

    // ==========================================================
    // State
    srctl_state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [`SRCTL_BANKS-1:0] sel_n_q, sel_n_d;
    logic write_n_q, write_n_d;
    logic data_in_q, data_in_d;
    logic ready_q, ready_d;
    logic rsp_valid_q, rsp_valid_d;
    logic rdata_q, rdata_d;
    logic rd_sync;

    srctl_sync u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .async_in(data_out),
        .sync_out(rd_sync)
    );

    // ==========================================================
    // Decode
    wire logic take = req_valid && ready_q;
    wire logic cnt_done = (cnt_q == 4'h1);
    wire logic [3:0] cnt_dec = cnt_q - 4'h1;
    wire logic bank_hi = req_addr[ADDR_W];
    // One address bit straight to one select, its complement to the other
    wire logic [`SRCTL_BANKS-1:0] sel_pick = {~bank_hi, bank_hi}; // [R9] [R3] [R10]

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        addr_d = addr_q;
        sel_n_d = sel_n_q;
        write_n_d = write_n_q;
        data_in_d = data_in_q;
        ready_d = ready_q;
        rsp_valid_d = 1'b0;
        rdata_d = rdata_q;
        unique case (state_q)
            SRCTL_IDLE: begin
                if (take) begin
                    addr_d = req_addr[ADDR_W-1:0]; // [R2] [R1]
                    sel_n_d = sel_pick;
                    ready_d = 1'b0;
                    if (req_write) begin
                        data_in_d = req_wdata; // [R6] [R8]
                        cnt_d = SETUP_C;
                        state_d = SRCTL_WSETUP;
                    end else begin
                        cnt_d = ACCESS_C;
                        state_d = SRCTL_RWAIT; // [R7]
                    end
                end
            end
            SRCTL_WSETUP: begin
                cnt_d = cnt_dec;
                if (cnt_done) begin
                    write_n_d = 1'b0; // [R5]
                    cnt_d = PULSE_C;
                    state_d = SRCTL_WPULSE;
                end
            end
            SRCTL_WPULSE: begin
                cnt_d = cnt_dec;
                if (cnt_done) begin
                    write_n_d = 1'b1;
                    cnt_d = HOLD_C;
                    state_d = SRCTL_WHOLD;
                end
            end
            SRCTL_WHOLD: begin
                cnt_d = cnt_dec;
                if (cnt_done) begin
                    // Address and data held until here, then deselect
                    sel_n_d = '1; // [R12]
                    cnt_d = RECOV_C;
                    state_d = SRCTL_RECOV;
                end
            end
            SRCTL_RWAIT: begin
                cnt_d = cnt_dec;
                if (cnt_done) begin
                    rdata_d = rd_sync; // [R8]
                    rsp_valid_d = 1'b1;
                    sel_n_d = '1;
                    cnt_d = RECOV_C;
                    state_d = SRCTL_RECOV;
                end
            end
            SRCTL_RECOV: begin
                cnt_d = cnt_dec;
                if (cnt_done) begin
                    ready_d = 1'b1;
                    state_d = SRCTL_IDLE;
                end
            end
            default: begin
                state_d = SRCTL_IDLE;
                sel_n_d = '1;
                write_n_d = 1'b1;
                ready_d = 1'b1;
            end
        endcase
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= SRCTL_IDLE;
            cnt_q <= 4'h0;
            addr_q <= '0;
            sel_n_q <= '1;
            write_n_q <= 1'b1;
            data_in_q <= 1'b0;
            ready_q <= 1'b1;
            rsp_valid_q <= 1'b0;
            rdata_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            addr_q <= addr_d;
            sel_n_q <= sel_n_d;
            write_n_q <= write_n_d;
            data_in_q <= data_in_d;
            ready_q <= ready_d;
            rsp_valid_q <= rsp_valid_d;
            rdata_q <= rdata_d;
        end
    end

    assign word_address = addr_q;
    assign sel_n = sel_n_q;
    assign write_n = write_n_q;
    assign data_in = data_in_q;
    assign req_ready = ready_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp_rdata = rdata_q;

    // ==========================================================
    // Checks
    one_select_a: assert property (@(posedge clock) disable iff (!rst_n) // [R9]
        sel_n_q != 2'b00)
        else $error("both devices selected");
    strobe_sel_a: assert property (@(posedge clock) disable iff (!rst_n) // [R3]
        !write_n_q |-> sel_n_q != 2'b11)
        else $error("strobe low while deselected");
    data_stable_a: assert property (@(posedge clock) disable iff (!rst_n) // [R6]
        (state_q != SRCTL_IDLE && state_q != SRCTL_RECOV && $past(state_q) != SRCTL_IDLE)
        |-> $stable(data_in_q) && $stable(addr_q))
        else $error("data or address moved during access");
    pulse_len_a: assert property (@(posedge clock) disable iff (!rst_n) // [R5]
        $fell(write_n_q) |-> !write_n_q [*1] ##1 write_n_q)
        else $error("write strobe width wrong");
    write_addr_a: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
        (take && req_write) |=> addr_q == $past(req_addr[ADDR_W-1:0])
        && sel_n_q == $past(sel_pick))
        else $error("write address not captured");
    read_no_wr_a: assert property (@(posedge clock) disable iff (!rst_n) // [R7]
        state_q == SRCTL_RWAIT |-> write_n_q)
        else $error("strobe low during read");
    read_resp_a: assert property (@(posedge clock) disable iff (!rst_n) // [R8]
        (take && !req_write) |-> ##4 rsp_valid_q)
        else $error("read answer not on time");
    recov_ready_a: assert property (@(posedge clock) disable iff (!rst_n) // [R12]
        rsp_valid_q |-> !ready_q ##1 ready_q)
        else $error("ready not back after recovery");
endmodule
`default_nettype wire

/* test/srctl_ram_model.sv */
// Behavioural model of one 1Kx1 static RAM device
`timescale 1ns/100ps
`default_nettype none
module srctl_ram_model (
    input wire logic [9:0] word_address,
    input wire logic sel_n,
    input wire logic write_n,
    input wire logic data_in,
    output logic data_out
);
    // ========================================
    // Storage, written while selected with strobe low
    logic mem [1024];
    always @(word_address or sel_n or write_n or data_in) begin
        if (!sel_n && !write_n) begin
            mem[word_address] = data_in;
        end
    end
    // ========================================
    // Output, pulled low unless selected and reading
    assign data_out = (!sel_n && write_n) ? mem[word_address] : 1'b0;
endmodule
`default_nettype wire

/* test/tb_top.sv */
// Testbench for the static RAM controller with two device models
`timescale 1ns/100ps
`default_nettype none
`include "srctl_map.svh"
module tb_top;
    logic clock, rst_n, req_valid, req_write, req_wdata, req_ready, rsp_valid, rsp_rdata;
    logic write_n, data_in, data_out, rd;
    logic [10:0] req_addr;
    logic [9:0] word_address;
    logic [1:0] sel_n;
    wire logic [1:0] q;
    int err_total, checks_done;
    // ========================================
    // Clock, design and devices
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    assign data_out = q[0] | q[1];
    srctl_top srctl_top_inst (.clock(clock), .rst_n(rst_n), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .word_address(word_address), .sel_n(sel_n), .write_n(write_n),
        .data_in(data_in), .data_out(data_out));
    srctl_ram_model srctl_ram_model_inst (.word_address(word_address), .sel_n(sel_n[0]),
        .write_n(write_n), .data_in(data_in), .data_out(q[0]));
    srctl_ram_model srctl_ram_model_inst1 (.word_address(word_address), .sel_n(sel_n[1]),
        .write_n(write_n), .data_in(data_in), .data_out(q[1]));
    // ========================================
    // Shared tasks
    task automatic check(string what, logic [10:0] exp, logic [10:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic op(input logic wr, input logic [10:0] a, input logic d);
        int n;
        int wlow;
        int rv;
        n = 0;
        wlow = 0;
        rv = -1;
        rd = 1'bx;
        while (req_ready !== 1'b1 && n < 20) begin
            @(posedge clock);
            #1 n++;
        end
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        @(posedge clock);
        #1 req_valid = 1'b0;
        check("sel_n", {9'h000, a[10] ? 2'b01 : 2'b10}, {9'h000, sel_n});
        check("word_address", {1'b0, a[9:0]}, {1'b0, word_address});
        for (n = 0; n < 12; n++) begin
            @(posedge clock);
            #1;
            if (write_n === 1'b0) wlow++;
            if (wr && sel_n !== 2'b11) begin
                check("data_in", {10'h000, d}, {10'h000, data_in});
            end
            if (rsp_valid === 1'b1) begin
                rd = rsp_rdata;
                rv = n;
            end
            if (req_ready === 1'b1) break;
        end
        check("req_ready", 11'h001, {10'h000, req_ready});
        check("rsp_valid cycle", wr ? 11'h7FF : 11'(`SRCTL_ACCESS_CYC - 1), 11'(rv));
        check("busy cycles", wr ? 11'(`SRCTL_SETUP_CYC + `SRCTL_PULSE_CYC + `SRCTL_HOLD_CYC
            + `SRCTL_RECOV_CYC - 1) : 11'(`SRCTL_ACCESS_CYC + `SRCTL_RECOV_CYC - 1),
            11'(n));
        check("write pulse", {10'h000, wr}, {10'h000, wlow > 0});
        check("sel_n idle", 11'h003, {9'h000, sel_n});
    endtask
    task automatic rd_chk(input logic [10:0] a, input logic exp);
        op(1'b0, a, 1'b0);
        check("rsp_rdata", {10'h000, exp}, {10'h000, rd});
    endtask
    // ========================================
    // Scenarios
    task automatic t_reset();
        check("idle pins", 11'h017, {7'h00, req_ready, rsp_valid, sel_n, write_n});
        check("idle address", 11'h000, {word_address, data_in});
        check("idle rdata", 11'h000, {10'h000, rsp_rdata});
    endtask
    task automatic t_midreset();
        req_valid = 1'b1;
        req_write = 1'b0;
        req_addr = 11'h405;
        @(posedge clock);
        #1 req_valid = 1'b0;
        rst_n = 1'b0;
        #1 check("reset pins", 11'h017, {7'h00, req_ready, rsp_valid, sel_n, write_n});
        @(posedge clock);
        #1 rst_n = 1'b1;
        rd_chk(11'h405, 1'b0);
    endtask
    task automatic t_banks();
        logic [9:0] ad [3] = '{10'h000, 10'h3FF, 10'h155};
        for (int b = 0; b < 2; b++) begin
            for (int i = 0; i < 3; i++) op(1'b1, {b[0], ad[i]}, b[0] ^ i[0]);
        end
        for (int b = 0; b < 2; b++) begin
            for (int i = 0; i < 3; i++) rd_chk({b[0], ad[i]}, b[0] ^ i[0]);
        end
    endtask
    task automatic t_alias();
        op(1'b1, 11'h005, 1'b1);
        op(1'b1, 11'h405, 1'b0);
        rd_chk(11'h005, 1'b1);
        rd_chk(11'h405, 1'b0);
        rd_chk(11'h005, 1'b1);
        op(1'b1, 11'h005, 1'b0);
        rd_chk(11'h005, 1'b0);
        rd_chk(11'h000, 1'b0);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ========================================
    // Main sequence and watchdog
    initial begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 11'h000;
        req_wdata = 1'b0;
        err_total = 0;
        checks_done = 0;
        repeat (2) @(posedge clock);
        #1 rst_n = 1'b1;
        t_reset();
        t_banks();
        t_alias();
        t_midreset();
        results();
    end
    initial begin
        #100000;
        err_total++;
        results();
    end
endmodule
`default_nettype wire
